/* File: common/aogc_pkg.sv */
// Package: register map, field sizes and constants of the offset/gain correction block
`default_nettype none
package aogc_pkg;
   localparam int DATA_W = 24;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 4;
   localparam int GAIN_FRAC = 22;                        // 400000h is unity
   localparam logic [23:0] GAIN_UNITY = 24'h400000;
   localparam logic [23:0] OFFSET_RESET = 24'h000000;
   localparam logic [23:0] POS_MAX = 24'h7fffff;
   localparam logic [23:0] NEG_MAX = 24'h800000;
   localparam int CAL_LEN = 16;
   localparam int CAL_SHIFT = 4;                         // log2 of CAL_LEN
   localparam int PGA_W = 3;
   // Register byte addresses
   localparam logic [3:0] REG_OFC0 = 4'h0;
   localparam logic [3:0] REG_OFC1 = 4'h1;
   localparam logic [3:0] REG_OFC2 = 4'h2;
   localparam logic [3:0] REG_GCW0 = 4'h3;
   localparam logic [3:0] REG_GCW1 = 4'h4;
   localparam logic [3:0] REG_GCW2 = 4'h5;
   localparam logic [3:0] REG_CTRL = 4'h6;               // [2:0] pga, [5:4] cal command
   localparam logic [3:0] REG_STAT = 4'h7;               // [0] cal busy, [1] ready_n
   localparam logic [3:0] REG_RES0 = 4'h8;
   localparam logic [3:0] REG_RES1 = 4'h9;
   localparam logic [3:0] REG_RES2 = 4'ha;
   // Calibration commands in REG_CTRL[5:4]
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_SYS_GAIN = 2'h1;
   localparam logic [1:0] CMD_SYS_OFS = 2'h2;
   localparam logic [1:0] CMD_SELF_OFS = 2'h3;
   localparam int CMD_LSB = 4;
endpackage
`default_nettype wire

/* File: logic/aogc_scale.sv */
// Combinational scaling: subtract offset, multiply by gain, clip to signed 24 bits
`default_nettype none
module aogc_scale (
   input wire logic [23:0] sample,
   input wire logic [23:0] offset_correction_word,
   input wire logic [23:0] gain_correction_word,
   output logic [23:0] result
);
   wire logic signed [24:0] diff;
   wire logic signed [49:0] prod;
   wire logic signed [27:0] scaled;
   wire logic too_big;
   wire logic too_small;
   // Widened by one bit so that -FS minus +FS cannot wrap
   assign diff = $signed({sample[23], sample}) - $signed({offset_correction_word[23],
      offset_correction_word});
   assign prod = diff * $signed({1'b0, gain_correction_word});
   assign scaled = prod[aogc_pkg::GAIN_FRAC +: 28];
   assign too_big = scaled > $signed({{4{1'b0}}, aogc_pkg::POS_MAX});
   assign too_small = scaled < $signed({{4{1'b1}}, aogc_pkg::NEG_MAX});
   // Saturate rather than wrap; a wrapped code would flip the sign of a full-scale input
   assign result = too_big ? aogc_pkg::POS_MAX :
                   too_small ? aogc_pkg::NEG_MAX : scaled[23:0];
endmodule
`default_nettype wire

/* File: logic/aogc_top.sv */
// Top: registers, calibration sequencer and output stage of the correction datapath
//
// Implementation choices: strobed register access and the placing of the registers.
`default_nettype none
module aogc_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [23:0] filt_data,
   input wire logic filt_valid,
   input wire logic [23:0] gain_trim_0,
   input wire logic [23:0] gain_trim_1,
   input wire logic [23:0] gain_trim_2,
   input wire logic [23:0] gain_trim_3,
   input wire logic [23:0] gain_trim_4,
   input wire logic [23:0] gain_trim_5,
   input wire logic [23:0] gain_trim_6,
   input wire logic [23:0] gain_trim_7,
   output logic [23:0] out_data,
   output logic out_valid,
   output logic result_ready_n
);
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_CAL = 2'b01
   } aogc_state_e;

   logic [23:0] offset_correction_word;
   logic [23:0] gain_correction_word;
   logic [2:0] pga;
   logic [2:0] pga_prev;
   logic pga_seen;
   logic [1:0] cal_cmd;
   aogc_state_e state;
   logic [4:0] cal_cnt;
   logic signed [27:0] cal_acc;
   wire logic [23:0] corrected;
   wire logic [23:0] trim_sel;
   wire logic [23:0] cal_avg;
   wire logic [23:0] gain_from_cal;
   wire logic [7:0] rd_mux;
   wire logic cmd_wr;
   wire logic cal_done;
   wire logic pga_changed;
   wire logic signed [27:0] sample_ext;

   aogc_scale u_scale (
      .sample(filt_data),
      .offset_correction_word(offset_correction_word),
      .gain_correction_word(gain_correction_word),
      .result(corrected)
   );

   // Factory trim selected by the current pga setting
   assign trim_sel = (pga == 3'h0) ? gain_trim_0 : (pga == 3'h1) ? gain_trim_1 :
                     (pga == 3'h2) ? gain_trim_2 : (pga == 3'h3) ? gain_trim_3 :
                     (pga == 3'h4) ? gain_trim_4 : (pga == 3'h5) ? gain_trim_5 :
                     (pga == 3'h6) ? gain_trim_6 : gain_trim_7;
   assign pga_changed = pga_seen && (pga != pga_prev);
   assign cmd_wr = wr && (addr == aogc_pkg::REG_CTRL) &&
                   (wdata[aogc_pkg::CMD_LSB +: 2] != aogc_pkg::CMD_NONE);
   assign sample_ext = {{4{filt_data[23]}}, filt_data};
   assign cal_done = (state == ST_CAL) && filt_valid &&
                     (cal_cnt == 5'(aogc_pkg::CAL_LEN - 1));
   // Average of the 16 conversions, including the one arriving now
   wire logic signed [27:0] cal_sum = cal_acc + sample_ext;
   assign cal_avg = cal_sum[aogc_pkg::CAL_SHIFT +: 24];
   // Gain cal: choose gain so the averaged full-scale input maps to full scale.
   // Simplified ratio: unity times (2^24 - 1) over the average; zero/negative keeps unity.
   wire logic [47:0] gain_num = {aogc_pkg::GAIN_UNITY, 24'h000000} - {24'h000000,
      aogc_pkg::GAIN_UNITY};
   wire logic [23:0] avg_pos = cal_avg[23] ? 24'h000000 : cal_avg;
   wire logic [47:0] gain_q = (avg_pos == 24'h000000) ? {24'h000000, aogc_pkg::GAIN_UNITY} :
      (gain_num / {24'h000000, avg_pos});
   assign gain_from_cal = (gain_q > {24'h000000, 24'hffffff}) ? 24'hffffff : gain_q[23:0];

   assign rd_mux = (addr == aogc_pkg::REG_OFC0) ? offset_correction_word[7:0] :
                   (addr == aogc_pkg::REG_OFC1) ? offset_correction_word[15:8] :
                   (addr == aogc_pkg::REG_OFC2) ? offset_correction_word[23:16] :
                   (addr == aogc_pkg::REG_GCW0) ? gain_correction_word[7:0] :
                   (addr == aogc_pkg::REG_GCW1) ? gain_correction_word[15:8] :
                   (addr == aogc_pkg::REG_GCW2) ? gain_correction_word[23:16] :
                   (addr == aogc_pkg::REG_CTRL) ? {2'h0, cal_cmd, 1'b0, pga} :
                   (addr == aogc_pkg::REG_STAT) ? {6'h00, result_ready_n, state == ST_CAL} :
                   (addr == aogc_pkg::REG_RES0) ? out_data[7:0] :
                   (addr == aogc_pkg::REG_RES1) ? out_data[15:8] :
                   (addr == aogc_pkg::REG_RES2) ? out_data[23:16] : 8'h00;

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? rd_mux : 8'h00;
      end
   end

   // Pga tracking; first cycle after reset only records the value
   always_ff @(posedge clk) begin
      if (rst) begin
         pga <= 3'h0;
         pga_prev <= 3'h0;
         pga_seen <= 1'b0;
      end else begin
         pga_prev <= pga;
         pga_seen <= 1'b1;
         if (wr && addr == aogc_pkg::REG_CTRL) begin
            pga <= wdata[2:0];
         end
      end
   end

   // Offset word: byte writes, or loaded by an offset calibration
   always_ff @(posedge clk) begin
      if (rst) begin
         offset_correction_word <= aogc_pkg::OFFSET_RESET;
      end else if (cal_done && cal_cmd != aogc_pkg::CMD_SYS_GAIN) begin
         offset_correction_word <= cal_avg;
      end else if (wr && addr == aogc_pkg::REG_OFC0) begin
         offset_correction_word[7:0] <= wdata;
      end else if (wr && addr == aogc_pkg::REG_OFC1) begin
         offset_correction_word[15:8] <= wdata;
      end else if (wr && addr == aogc_pkg::REG_OFC2) begin
         offset_correction_word[23:16] <= wdata;
      end
   end

   // Gain word: byte writes, gain cal result, or factory trim on pga change
   always_ff @(posedge clk) begin
      if (rst) begin
         gain_correction_word <= aogc_pkg::GAIN_UNITY;
      end else if (cal_done && cal_cmd == aogc_pkg::CMD_SYS_GAIN) begin
         gain_correction_word <= gain_from_cal;
      end else if (pga_changed) begin
         gain_correction_word <= trim_sel;
      end else if (wr && addr == aogc_pkg::REG_GCW0) begin
         gain_correction_word[7:0] <= wdata;
      end else if (wr && addr == aogc_pkg::REG_GCW1) begin
         gain_correction_word[15:8] <= wdata;
      end else if (wr && addr == aogc_pkg::REG_GCW2) begin
         gain_correction_word[23:16] <= wdata;
      end
   end

   // Calibration sequencer; a new command restarts any running calibration
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_RUN;
         cal_cmd <= aogc_pkg::CMD_NONE;
         cal_cnt <= 5'h00;
         cal_acc <= 28'h0000000;
      end else if (cmd_wr) begin
         state <= ST_CAL;
         cal_cmd <= wdata[aogc_pkg::CMD_LSB +: 2];
         cal_cnt <= 5'h00;
         cal_acc <= 28'h0000000;
      end else begin
         case (state)
            ST_RUN: begin
               cal_cnt <= 5'h00;
            end
            ST_CAL: begin
               if (filt_valid) begin
                  cal_acc <= cal_sum;
                  cal_cnt <= cal_cnt + 5'h01;
                  if (cal_done) begin
                     state <= ST_RUN;
                     cal_cmd <= aogc_pkg::CMD_NONE;
                  end
               end
            end
            default: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

   // Output stage; ready_n falls on a result or at the end of calibration
   always_ff @(posedge clk) begin
      if (rst) begin
         out_data <= 24'h000000;
         out_valid <= 1'b0;
         result_ready_n <= 1'b1;
      end else begin
         out_valid <= filt_valid && (state == ST_RUN);
         if (filt_valid && state == ST_RUN) begin
            out_data <= corrected;
            result_ready_n <= 1'b0;
         end else if (cal_done) begin
            result_ready_n <= 1'b0;
         end else if (rd && addr == aogc_pkg::REG_RES2) begin
            result_ready_n <= 1'b1;
         end
      end
   end

   // Checks on the datapath, the word updates and the calibration sequencer.
   // All of them sit in the system clock domain and are silenced while rst is high.
   property p_zero_offset_unity;
      @(posedge clk) disable iff (rst)
      (filt_valid && state == ST_RUN && offset_correction_word == 24'h000000 &&
       gain_correction_word == aogc_pkg::GAIN_UNITY) |=> (out_data == $past(filt_data));
   endproperty
   a_zero_offset_unity: assert property (p_zero_offset_unity) else $error("data altered");

   property p_out_follows;
      @(posedge clk) disable iff (rst)
      (filt_valid && state == ST_RUN) |=> (out_valid && out_data == $past(corrected));
   endproperty
   a_out_follows: assert property (p_out_follows) else $error("output not latched");

   property p_sat_pos;
      @(posedge clk) disable iff (rst)
      (filt_valid && state == ST_RUN && !filt_data[23] &&
       offset_correction_word == aogc_pkg::NEG_MAX &&
       gain_correction_word >= aogc_pkg::GAIN_UNITY)
      |=> (out_data == aogc_pkg::POS_MAX);
   endproperty
   a_sat_pos: assert property (p_sat_pos) else $error("positive overflow wrapped");

   // Most positive offset on a negative input must pin at the negative extreme
   property p_sat_neg;
      @(posedge clk) disable iff (rst)
      (filt_valid && state == ST_RUN && filt_data[23] &&
       offset_correction_word == aogc_pkg::POS_MAX &&
       gain_correction_word >= aogc_pkg::GAIN_UNITY)
      |=> (out_data == aogc_pkg::NEG_MAX);
   endproperty
   a_sat_neg: assert property (p_sat_neg) else $error("negative overflow wrapped");

   property p_cal_ready;
      @(posedge clk) disable iff (rst)
      cal_done && !cmd_wr |=> (!result_ready_n && state == ST_RUN);
   endproperty
   a_cal_ready: assert property (p_cal_ready) else $error("cal end not flagged");

   property p_pga_reload;
      @(posedge clk) disable iff (rst)
      (pga_changed && !cal_done) |=> (gain_correction_word == $past(trim_sel));
   endproperty
   a_pga_reload: assert property (p_pga_reload) else $error("trim not reloaded");

   property p_ofs_write;
      @(posedge clk) disable iff (rst)
      (wr && addr == aogc_pkg::REG_OFC1 && !cal_done)
      |=> (offset_correction_word[15:8] == $past(wdata));
   endproperty
   a_ofs_write: assert property (p_ofs_write) else $error("offset byte lost");

   property p_gain_write;
      @(posedge clk) disable iff (rst)
      (wr && addr == aogc_pkg::REG_GCW2 && !cal_done && !pga_changed)
      |=> (gain_correction_word[23:16] == $past(wdata));
   endproperty
   a_gain_write: assert property (p_gain_write) else $error("gain byte lost");

   property p_cal_load;
      @(posedge clk) disable iff (rst)
      (cal_done && cal_cmd != aogc_pkg::CMD_SYS_GAIN)
      |=> (offset_correction_word == $past(cal_avg));
   endproperty
   a_cal_load: assert property (p_cal_load) else $error("cal average not loaded");

   property p_gain_cal;
      @(posedge clk) disable iff (rst)
      (cal_done && cal_cmd == aogc_pkg::CMD_SYS_GAIN)
      |=> (gain_correction_word == $past(gain_from_cal));
   endproperty
   a_gain_cal: assert property (p_gain_cal) else $error("gain cal not loaded");

   // A command always starts counting from zero, even over a running calibration
   property p_cal_busy;
      @(posedge clk) disable iff (rst)
      cmd_wr |=> (state == ST_CAL && cal_cnt == 5'h00);
   endproperty
   a_cal_busy: assert property (p_cal_busy) else $error("cal not started");

   property p_cal_quiet;
      @(posedge clk) disable iff (rst)
      (state == ST_CAL) |=> !out_valid;
   endproperty
   a_cal_quiet: assert property (p_cal_quiet) else $error("output during calibration");

   property p_ready_clear;
      @(posedge clk) disable iff (rst)
      (rd && addr == aogc_pkg::REG_RES2 && !(filt_valid && state == ST_RUN) && !cal_done)
      |=> result_ready_n;
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

   property p_rdata_idle;
      @(posedge clk) disable iff (rst)
      !rd |=> (rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule
`default_nettype wire

/* File: verification/aogc_filt_model.sv */
// Partner model: decimation filter output stage and factory gain trim store
`default_nettype none
module aogc_filt_model (
   input wire logic clk,
   output logic [23:0] filt_data,
   output logic filt_valid,
   output logic [23:0] gain_trim [8]
);
   timeunit 1ns;
   timeprecision 100ps;

   // Distinct trims per gain setting so a wrong pick shows up
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         gain_trim[k] = 24'h3c0000 + 24'(k) * 24'h000101;
      end
   end

   initial begin
      filt_data = 24'h000000;
      filt_valid = 1'b0;
   end

   // One result per call; the data lines show garbage outside the valid pulse
   task automatic emit(input logic [23:0] v);
      @(posedge clk);
      filt_data <= v;
      filt_valid <= 1'b1;
      @(posedge clk);
      filt_valid <= 1'b0;
      filt_data <= ~v;
   endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Testbench of the offset/gain correction block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [23:0] o; logic [23:0] g; logic [23:0] s; logic [23:0] e;} aogc_row_s;
   logic clk, rst, wr, rd, out_valid, result_ready_n;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, b;
   logic [23:0] filt_data, out_data;
   logic filt_valid;
   logic [23:0] gain_trim [8];
   int failures = 0;
   int num_checks = 0;
   int seen;
   logic [1:0] cmds [3] = '{aogc_pkg::CMD_SYS_OFS, aogc_pkg::CMD_SELF_OFS,
      aogc_pkg::CMD_SYS_GAIN};
   aogc_row_s rows [11] = '{
      '{24'h000000, 24'h400000, 24'h123456, 24'h123456}, // zero offset, unity gain
      '{24'h7fffff, 24'h400000, 24'h000000, 24'h800001},
      '{24'hffffff, 24'h400000, 24'h000000, 24'h000001},
      '{24'h800000, 24'h400000, 24'h000000, 24'h7fffff}, // Difference overflows
      '{24'h000000, 24'h800000, 24'h000100, 24'h000200},
      '{24'h000000, 24'h200000, 24'h000200, 24'h000100},
      '{24'h000000, 24'h800000, 24'h500000, 24'h7fffff},
      '{24'h000000, 24'h800000, 24'hb00000, 24'h800000},
      '{24'h000010, 24'h000000, 24'h000123, 24'h000000},
      '{24'h000100, 24'h400000, 24'h000300, 24'h000200},
      '{24'h7fffff, 24'h400000, 24'h800000, 24'h800000}}; // Negative overflow

   aogc_filt_model fm (.clk(clk), .filt_data(filt_data), .filt_valid(filt_valid),
      .gain_trim(gain_trim));

   aogc_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .filt_data(filt_data), .filt_valid(filt_valid),
      .gain_trim_0(gain_trim[0]), .gain_trim_1(gain_trim[1]), .gain_trim_2(gain_trim[2]),
      .gain_trim_3(gain_trim[3]), .gain_trim_4(gain_trim[4]), .gain_trim_5(gain_trim[5]),
      .gain_trim_6(gain_trim[6]), .gain_trim_7(gain_trim[7]), .out_data(out_data),
      .out_valid(out_valid), .result_ready_n(result_ready_n));

   // Clock at 125 MHz
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bus cycles leave one idle cycle so no strobe is driven twice in a time step
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic set_word(input logic [3:0] base, input logic [23:0] v);
      for (int i = 0; i < 3; i++) wr_reg(base + 4'(i), v[8*i +: 8]);
   endtask

   task automatic chk_word(input logic [3:0] base, input logic [23:0] v);
      for (int i = 0; i < 3; i++) begin
         rd_reg(base + 4'(i), b);
         chk({16'h0000, b}, {16'h0000, v[8*i +: 8]});
      end
   endtask

   task automatic complete_run();
      if (failures == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      complete_run();
   end

   initial begin
      rst = 1'b1;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1 chk({23'h0, result_ready_n}, 24'h000001);
      chk({23'h0, out_valid}, 24'h000000);
      chk_word(aogc_pkg::REG_OFC0, aogc_pkg::OFFSET_RESET);
      chk_word(aogc_pkg::REG_GCW0, aogc_pkg::GAIN_UNITY);
      // Table of corrections, each through host-written words
      foreach (rows[i]) begin
         set_word(aogc_pkg::REG_OFC0, rows[i].o);
         set_word(aogc_pkg::REG_GCW0, rows[i].g);
         fm.emit(rows[i].s);
         #1 chk({23'h0, out_valid}, 24'h000001);
         chk(out_data, rows[i].e);
         chk({23'h0, result_ready_n}, 24'h000000);
         chk_word(aogc_pkg::REG_RES0, rows[i].e);
      end
      chk_word(aogc_pkg::REG_OFC0, rows[10].o);
      // Offset cals see 0,2..30 (average 0fh); the gain cal sees full scale on every sample
      for (int i = 0; i < 3; i++) begin
         rd_reg(aogc_pkg::REG_RES2, b);
         set_word(aogc_pkg::REG_OFC0, 24'h000055);
         wr_reg(aogc_pkg::REG_CTRL, {2'b00, cmds[i], 4'h0});
         rd_reg(aogc_pkg::REG_STAT, b);
         chk({16'h0, b}, 24'h000003);
         seen = 0;
         for (int k = 0; k < 16; k++) begin
            fm.emit((i == 2) ? aogc_pkg::POS_MAX : 24'(2 * k));
            #1 seen += int'(out_valid === 1'b1);
         end
         @(posedge clk);
         #1 chk({23'h0, result_ready_n}, 24'h000000);
         chk(24'(seen), 24'h000000);
         chk_word(aogc_pkg::REG_OFC0, (i == 2) ? 24'h000055 : 24'h00000f);
      end
      // Gain cal: unity times (2^24 - 1) over a 7fffffh average is twice unity
      chk_word(aogc_pkg::REG_GCW0, 24'h800000);
      // Gain setting change reloads the factory trim
      wr_reg(aogc_pkg::REG_CTRL, 8'h03);
      repeat (3) @(posedge clk);
      chk_word(aogc_pkg::REG_GCW0, 24'h3c0303);
      rd_reg(aogc_pkg::REG_CTRL, b);
      chk({16'h0, b}, 24'h000003);
      // Read data fall back to zero in the cycle after their slot
      @(posedge clk);
      #1 chk({16'h0, rdata}, 24'h000000);
      rd_reg(4'hb, b);
      chk({16'h0, b}, 24'h000000);
      // Reset in mid-run puts every word back to its power-on value
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 chk({23'h0, result_ready_n}, 24'h000001);
      chk(out_data, 24'h000000);
      chk_word(aogc_pkg::REG_OFC0, aogc_pkg::OFFSET_RESET);
      chk_word(aogc_pkg::REG_GCW0, aogc_pkg::GAIN_UNITY);
      complete_run();
   end
endmodule
`default_nettype wire
